// ### dv/cpu_compare_pwm_bench.sv
// bench: compare and pwm channel driven against the timer model
`timescale 1ns/100ps
`default_nettype none
module cpu_compare_pwm_bench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  ctrl = 8'h00, rh = 8'h00, rl = 8'h00, wd = 8'h00;
   logic        we = 1'b0, adc_en = 1'b0;
   logic [7:0]  per = 8'h03;
   wire  [15:0] t1;
   wire  [7:0]  t2, hi;
   wire  [1:0]  ph;
   wire         t1e, t2i, irq, trig, t1r, adc, blk, clr, pin, oe;
   int          n_errors = 0, total_checks = 0, i, n;
   logic [3:0]  cm [5] = '{4'h2, 4'h9, 4'h8, 4'h2, 4'h8};
   logic        cp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   // system clock, 5 ns period
   always #2.5 clk = ~clk;
   cpu_timer_model tm_u (.clk_i(clk), .rst_n_i(rst_n), .t1_reset_i(t1r),
      .t2_clear_i(clr), .t1_count_o(t1), .t1_edge_o(t1e), .t2_count_o(t2),
      .phase_o(ph), .t2_inc_o(t2i));
   cpu_compare_pwm dut_u (.clk_i(clk), .rst_n_i(rst_n),
      .channel_control_i(ctrl), .compare_ref_high_i(rh),
      .compare_ref_low_i(rl), .duty_high_we_i(we), .duty_high_wdata_i(wd),
      .timer_one_count_high_i(t1[15:8]), .timer_one_count_low_i(t1[7:0]),
      .timer_one_edge_i(t1e), .timer_two_count_i(t2),
      .pwm_period_reg_i(per), .timer_two_prescale_sel_i(2'h0),
      .timer_two_phase_i(ph), .timer_two_inc_i(t2i), .adc_enable_i(adc_en),
      .channel_irq_flag_set_o(irq), .special_trigger_o(trig),
      .timer_one_reset_o(t1r), .adc_start_o(adc),
      .timer_one_overflow_block_o(blk), .timer_two_clear_o(clr),
      .compare_ref_high_o(hi), .channel_pin_o(pin), .channel_pin_oe_o(oe));
   // compare one value, count it
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask
   // bounded wait on the match pulse or the period end pulse
   task automatic wait_on(input bit use_clr, input int lim);
      for (int k = 0; k < lim; k++) begin
         @(negedge clk);
         if ((use_clr ? clr : irq) === 1'b1) return;
      end
      chk("wait bound", 16'h1, 16'h0);
      report_and_stop;
   endtask
   // arm a compare mode with a reference a few timer steps ahead
   task automatic cmp_run(input logic [3:0] m, input logic a);
      logic [15:0] base;
      // timer one is read where it is settled, away from its edge
      @(negedge clk);
      base = t1;
      @(posedge clk);
      ctrl <= {4'h0, m};
      adc_en <= a;
      {rh, rl} <= base + 16'h0008;
      wait_on(1'b0, 400);
   endtask
   // load a duty in the first cycle of a period, then measure the following period
   task automatic pwm_run(input logic [7:0] dh, input logic [1:0] db,
                          input logic [15:0] ex, input bit cpv);
      logic [7:0] prev;
      prev = hi;
      // timer two may have to wrap through its full range first
      wait_on(1'b1, 1100);
      @(posedge clk);
      rl <= dh;
      ctrl <= {2'h0, db, 4'hC};
      we <= 1'b1;
      wd <= ~dh;
      @(posedge clk);
      we <= 1'b0;
      @(negedge clk);
      if (cpv) chk("held duty", prev, hi);
      wait_on(1'b1, 40);
      n = 0;
      for (i = 0; i < 16; i++) begin
         @(negedge clk);
         n += pin;
      end
      chk("period end", 16'h1, clr);
      chk("high cycles", ex, 16'(n));
      chk("active duty", dh, hi);
      chk("pwm oe", 16'h1, oe);
   endtask
   // verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int j = 0; j < 5; j++) begin
         cmp_run(cm[j], 1'b0);
         @(negedge clk);
         chk("match pin", cp[j], pin);
         chk("match oe", 16'h1, oe);
      end
      @(posedge clk);
      ctrl <= 8'h00;
      // the latch clears at the edge after the control write
      repeat (2) @(negedge clk);
      chk("cleared pin", 16'h0, pin);
      $display("compare pin test done");
      cmp_run(4'hA, 1'b0);
      chk("sw trigger", 16'h0, trig);
      chk("sw oe", 16'h0, oe);
      cmp_run(4'hB, 1'b1);
      chk("trigger", 16'h1, trig);
      chk("adc start", 16'h1, adc);
      chk("special oe", 16'h0, oe);
      for (i = 0; i < 6; i++) begin
         @(negedge clk);
         if (t1r === 1'b1) break;
      end
      chk("timer one reset", 16'h1, t1r);
      chk("overflow block", 16'h1, blk);
      @(negedge clk);
      chk("timer one count", 16'h0, t1);
      cmp_run(4'hB, 1'b0);
      chk("adc idle", 16'h0, adc);
      @(posedge clk);
      rh <= rh + 8'h80;
      n = 0;
      repeat (8) begin
         @(negedge clk);
         n += t1r;
      end
      chk("cancelled reset", 16'h0, 16'(n));
      $display("special trigger test done");
      @(posedge clk);
      ctrl <= 8'h0C;
      pwm_run(8'h01, 2'h1, 16'h0005, 1'b0);
      pwm_run(8'h00, 2'h1, 16'h0001, 1'b1);
      pwm_run(8'h00, 2'h0, 16'h0000, 1'b1);
      pwm_run(8'h05, 2'h0, 16'h0010, 1'b1);
      pwm_run(8'h01, 2'h1, 16'h0005, 1'b1);
      @(posedge clk);
      ctrl <= 8'h00;
      @(negedge clk);
      chk("released oe", 16'h0, oe);
      $display("pwm test done");
      report_and_stop;
   end
endmodule
`default_nettype wire

// ### dv/cpu_timer_model.sv
// partner model: timer one and timer two counters at 1:1 prescale
`timescale 1ns/100ps
`default_nettype none
module cpu_timer_model (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        t1_reset_i,
   input  wire logic        t2_clear_i,
   output logic      [15:0] t1_count_o,
   output logic             t1_edge_o,
   output logic      [7:0]  t2_count_o,
   output logic      [1:0]  phase_o,
   output logic             t2_inc_o
);
   // timer one steps once per instruction cycle, never per system clock
   assign t1_edge_o = (phase_o == 2'h3);
   assign t2_inc_o  = (phase_o == 2'h3);
   // counters: a clear or reset request wins over the increment
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_o    <= 2'h0;
         t1_count_o <= 16'h0000;
         t2_count_o <= 8'h00;
      end else begin
         phase_o <= phase_o + 2'h1;
         if (t1_edge_o) begin
            t1_count_o <= t1_reset_i ? 16'h0000 : t1_count_o + 16'h0001;
         end
         if (t2_inc_o) begin
            t2_count_o <= t2_clear_i ? 8'h00 : t2_count_o + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ### verilog/cpu_compare_pwm.sv
// module: compare and standard pwm channel
`timescale 1ns/100ps
`default_nettype none
module cpu_compare_pwm (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  channel_control_i,
   input  wire logic [7:0]  compare_ref_high_i,
   input  wire logic [7:0]  compare_ref_low_i,
   input  wire logic        duty_high_we_i,
   input  wire logic [7:0]  duty_high_wdata_i,
   input  wire logic [7:0]  timer_one_count_high_i,
   input  wire logic [7:0]  timer_one_count_low_i,
   input  wire logic        timer_one_edge_i,
   input  wire logic [7:0]  timer_two_count_i,
   input  wire logic [7:0]  pwm_period_reg_i,
   input  wire logic [1:0]  timer_two_prescale_sel_i,
   input  wire logic [1:0]  timer_two_phase_i,
   input  wire logic        timer_two_inc_i,
   input  wire logic        adc_enable_i,
   output logic             channel_irq_flag_set_o,
   output logic             special_trigger_o,
   output logic             timer_one_reset_o,
   output logic             adc_start_o,
   output logic             timer_one_overflow_block_o,
   output logic             timer_two_clear_o,
   output logic [7:0]       compare_ref_high_o,
   output logic             channel_pin_o,
   output logic             channel_pin_oe_o
);
   // timer counts, phases and edge strobes all arrive as ports
   // control field split, each mode a named wire
   logic [3:0] mode;
   logic [1:0] duty_low_bits;
   logic       is_off;
   logic       is_toggle;
   logic       is_set;
   logic       is_clear;
   logic       is_sw_irq;
   logic       is_special;
   logic       is_pwm;
   logic       is_compare;
   assign mode          = channel_control_i[3:0];
   assign duty_low_bits = channel_control_i[5:4];
   assign is_off     = (mode == cpu_pkg::MODE_OFF);
   assign is_toggle  = (mode == cpu_pkg::MODE_TOGGLE);
   assign is_set     = (mode == cpu_pkg::MODE_SET);
   assign is_clear   = (mode == cpu_pkg::MODE_CLEAR);
   assign is_sw_irq  = (mode == cpu_pkg::MODE_SW_IRQ);
   assign is_special = (mode == cpu_pkg::MODE_SPECIAL);
   assign is_pwm     = (mode[3:2] == cpu_pkg::MODE_PWM_TOP);
   assign is_compare = is_toggle | is_set | is_clear | is_sw_irq | is_special;

   // full 16-bit equality, evaluated every system clock cycle; with that
   // clock stopped nothing is compared or acted on
   logic [15:0] ref_word;
   logic [15:0] t1_word;
   logic        match;
   assign ref_word = {compare_ref_high_i, compare_ref_low_i};
   assign t1_word  = {timer_one_count_high_i, timer_one_count_low_i};
   assign match    = is_compare && (ref_word == t1_word);

   // one pulse per entry into equality, not every held cycle
   logic match_q;
   logic match_rise;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         match_q <= 1'b0;
      end else begin
         match_q <= match;
      end
   end
   assign match_rise = match & ~match_q;

   // interrupt flag pulse in the same cycle as the action
   assign channel_irq_flag_set_o = match_rise;
   assign special_trigger_o      = match_rise & is_special;

   // pending timer1 reset waits for the timer1 clock edge
   logic       pend_q;
   logic       pend_d;
   logic [15:0] pend_ref_q;
   logic       ref_changed;
   logic       fire_reset;
   assign ref_changed = (pend_ref_q != ref_word);
   // reference moved before the edge: drop the reset
   assign fire_reset  = pend_q & timer_one_edge_i & ~ref_changed
                        & is_special;
   assign pend_d = special_trigger_o ? 1'b1 :
                   (timer_one_edge_i | ref_changed | ~is_special) ? 1'b0 :
                   pend_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_q     <= 1'b0;
         pend_ref_q <= '0;
      end else begin
         pend_q     <= pend_d;
         if (special_trigger_o) begin
            pend_ref_q <= ref_word;
         end
      end
   end
   assign timer_one_reset_o = fire_reset;
   // timer1 overflow flag is suppressed for this reset
   assign timer_one_overflow_block_o = fire_reset;
   assign adc_start_o = special_trigger_o & adc_enable_i;

   // compare output latch: toggle, set or clear on match
   logic cmp_out_q;
   logic cmp_out_d;
   assign cmp_out_d = is_off ? cpu_pkg::OUT_LATCH_RST :
                      (match_rise & is_toggle) ? ~cmp_out_q :
                      (match_rise & is_set)    ? 1'b1 :
                      (match_rise & is_clear)  ? 1'b0 :
                      cmp_out_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmp_out_q <= cpu_pkg::OUT_LATCH_RST;
      end else begin
         cmp_out_q <= cmp_out_d;
      end
   end

   // period end: increment while Timer2 equals the period value
   logic period_end;
   assign period_end = is_pwm & timer_two_inc_i
                       & (timer_two_count_i == pwm_period_reg_i);
   // postscaler never enters here, so the period is (pr+1)*4*prescale
   assign timer_two_clear_o = period_end;

   // buffered duty: low register is the upper eight bits
   logic [9:0] duty_buffered;
   logic [9:0] duty_active;
   assign duty_buffered = {compare_ref_low_i, duty_low_bits};
   cpu_duty_buffer #(
      .WIDTH      (cpu_pkg::DUTY_WIDTH)
   ) u_duty (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .load_i     (period_end),
      .buffered_i (duty_buffered),
      .active_o   (duty_active)
   );

   // duty high copy is software writable outside pwm only
   logic [7:0] ref_high_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ref_high_q <= cpu_pkg::DUTY_HIGH_RST;
      end else if (is_pwm) begin
         ref_high_q <= duty_active[9:2];
      end else if (duty_high_we_i) begin
         ref_high_q <= duty_high_wdata_i;
      end
   end
   assign compare_ref_high_o = ref_high_q;

   // ten-bit time base: phase bits as the low two bits at every prescale setting
   logic [1:0] low_base;
   logic [9:0] time_base;
   assign low_base  = timer_two_phase_i;
   assign time_base = {timer_two_count_i, low_base};
   logic duty_zero;
   logic duty_hit;
   assign duty_zero = (duty_buffered == 10'h000);
   // the pin is a register, so the hit is taken one step early and the
   // pin falls as the time base reaches the duty; a duty beyond the
   // period never matches so the pin stays put
   logic [9:0] time_base_next;
   assign time_base_next = time_base + 10'h001;
   assign duty_hit  = (time_base_next == duty_active);

   // pwm pin latch
   logic pwm_q;
   logic pwm_d;
   assign pwm_d = ~is_pwm     ? 1'b0 :
                  period_end  ? ~duty_zero :
                  duty_hit    ? 1'b0 :
                  pwm_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_q <= 1'b0;
      end else begin
         pwm_q <= pwm_d;
      end
   end

   // pin ownership: released when off, in 1010 and in 1011
   assign channel_pin_oe_o = is_pwm | is_toggle | is_set | is_clear;
   assign channel_pin_o    = is_pwm ? pwm_q : cmp_out_q;

   // assertions: multi-step behaviours are built from named sequences
   sequence trig_s;
      special_trigger_o;
   endsequence
   // two quiet cycles with the reference held and the mode kept
   sequence hold_s;
      (!timer_one_edge_i && is_special && !ref_changed)[*2];
   endsequence
   // the timer1 clock edge that should carry the pending reset
   sequence edge_s;
      timer_one_edge_i && is_special && !ref_changed;
   endsequence

   // compare side
   irq_with_trig_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      special_trigger_o |-> channel_irq_flag_set_o)
      else $error("trigger without interrupt flag");
   trig_on_match_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      trig_s |-> (ref_word == t1_word))
      else $error("trigger without equality");
   no_early_reset_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      special_trigger_o |-> !timer_one_reset_o)
      else $error("timer1 reset in trigger cycle");
   reset_at_edge_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      trig_s ##1 hold_s ##1 edge_s |-> timer_one_reset_o)
      else $error("timer1 reset missing at its clock edge");
   ovf_block_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      timer_one_reset_o |-> timer_one_overflow_block_o)
      else $error("overflow not suppressed");
   ref_cancel_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (pend_q && ref_changed) |-> !timer_one_reset_o)
      else $error("reset after reference change");
   off_latch_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      is_off |=> !cmp_out_q)
      else $error("latch not cleared when off");
   pin_release_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (is_sw_irq || is_special || is_off) |-> !channel_pin_oe_o)
      else $error("pin driven in released mode");
   set_match_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (match_rise && is_set) |=> cmp_out_q)
      else $error("set on match failed");
   clear_match_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (match_rise && is_clear) |=> !cmp_out_q)
      else $error("clear on match failed");
   toggle_match_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (match_rise && is_toggle) |=> (cmp_out_q != $past(cmp_out_q)))
      else $error("toggle on match failed");
   adc_on_match_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      adc_start_o |-> (is_special && (ref_word == t1_word)))
      else $error("conversion start without special match");

   // pwm side
   period_load_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      period_end |=> (duty_active == $past(duty_buffered)))
      else $error("duty not loaded at period end");
   ref_high_ro_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (is_pwm && $past(is_pwm)) |->
      (compare_ref_high_o == $past(duty_active[9:2])))
      else $error("held duty copy written in pwm");
   pwm_set_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (period_end && !duty_zero) |=> pwm_q)
      else $error("pin not set at period end");
   pwm_zero_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (period_end && duty_zero) |=> !pwm_q)
      else $error("pin set with zero duty");
   duty_low_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (is_pwm && !period_end && duty_hit) |=> !pwm_q)
      else $error("pin not cleared at duty");
   pwm_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (is_pwm && !period_end && !duty_hit) |=> (pwm_q == $past(pwm_q)))
      else $error("pin moved without period end or duty hit");
   pwm_oe_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      is_pwm |-> channel_pin_oe_o)
      else $error("pin not driven in pwm");
endmodule
`default_nettype wire

// ### verilog/cpu_duty_buffer.sv
// module: double buffered pwm duty register
`timescale 1ns/100ps
`default_nettype none
module cpu_duty_buffer #(
   parameter int WIDTH = 10
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] buffered_i,
   output logic      [WIDTH-1:0] active_o
);
   // active copy loads only at period end so the output never glitches
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         active_o <= '0;
      end else if (load_i) begin
         active_o <= buffered_i;
      end
   end
endmodule
`default_nettype wire

// ### verilog/cpu_pkg.sv
// package: constants for the compare and pwm unit
package cpu_pkg;
   localparam logic [3:0] MODE_OFF       = 4'h0;
   localparam logic [3:0] MODE_TOGGLE    = 4'h2;
   localparam logic [3:0] MODE_SET       = 4'h8;
   localparam logic [3:0] MODE_CLEAR     = 4'h9;
   localparam logic [3:0] MODE_SW_IRQ    = 4'hA;
   localparam logic [3:0] MODE_SPECIAL   = 4'hB;
   localparam logic [1:0] MODE_PWM_TOP   = 2'h3;
   localparam int         REF_WIDTH      = 16;
   localparam int         DUTY_WIDTH     = 10;
   localparam int         TIMER_TWO_COUNT_WIDTH     = 8;
   localparam logic [1:0] PRESCALE_ONE   = 2'h0;
   localparam logic       OUT_LATCH_RST  = 1'b0;
   localparam logic [7:0] DUTY_HIGH_RST  = 8'h00;
   localparam logic [1:0] DUTY_LOW_RST   = 2'h0;
endpackage
